// *** hw/obcc_config.sv ***
// Purpose: Decode option byte 1 into clock, delay and pad configuration.
// Assumes: hclk is the CPU clock; option_byte is stable while in reset.
// Notes: AHB-Lite slave, zero wait states, always OKAY.
//
// The placing of the registers and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/10ps

// Overview of operation
// - Wait 4096 or 256 cycles after reset/halt
// - Source type selects resonator, RC, external
// - Range field sets resonator current source
// - External source forces medium power range
// - Package bit selects 44 or 32 leads
// - Unbonded pads reset as pulled-up inputs
module obcc_config #(
   parameter int NUM_PORTS = 4,
   parameter int PADS_PER_PORT = 8,
   parameter logic [31:0] BOND_MASK_44 = 32'hffff_ffff,
   parameter logic [31:0] BOND_MASK_32 = 32'h00ff_ffff
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire obcc_pkg::obcc_opt_s option_byte,
   input wire logic wakeup,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic cpu_run,
   output obcc_pkg::obcc_src_e clk_src_sel,
   output logic [2:0] osc_current_range,
   output logic pll_enable,
   output logic package_44,
   output logic [NUM_PORTS*PADS_PER_PORT-1:0] pad_pullup_input
);
   localparam int NPADS = NUM_PORTS * PADS_PER_PORT;

   // ---------------------------------------------------------------
   // Decode helpers
   // ---------------------------------------------------------------
   // Reserved code 01 falls back to the RC oscillator: it needs no
   // external part, so the device still starts.
   function automatic obcc_pkg::obcc_src_e src_decode(input logic [1:0] c);
      if (c == obcc_pkg::SRC_RESONATOR) begin
         return obcc_pkg::OBCC_SRC_RESONATOR;
      end else if (c == obcc_pkg::SRC_EXTERNAL) begin
         return obcc_pkg::OBCC_SRC_EXTERNAL;
      end else begin
         return obcc_pkg::OBCC_SRC_RC;
      end
   endfunction

   // External sources always run the range at medium power
   function automatic logic [2:0] range_decode(input obcc_pkg::obcc_opt_s o);
      if (src_decode(o.clock_source_type) == obcc_pkg::OBCC_SRC_EXTERNAL) begin
         return obcc_pkg::MEDIUM_POWER_RANGE;
      end else begin
         return o.oscillator_range;
      end
   endfunction

   // ---------------------------------------------------------------
   // Sequencer: load, stabilize, run, halt
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {ST_LOAD, ST_WAIT, ST_RUN, ST_HALT} obcc_state_e;

   obcc_state_e state, next_state;
   obcc_pkg::obcc_opt_s opt, next_opt;   // Frozen copy of the byte
   logic [obcc_pkg::CNT_W-1:0] cnt, next_cnt; // Stabilization count
   logic [obcc_pkg::CNT_W-1:0] delay_len; // Selected wait length
   logic next_cpu_run;
   logic halt_req;                       // Software asks for halt

   always_comb begin
      delay_len = opt.reset_delay_select ? obcc_pkg::SHORT_DELAY
                                         : obcc_pkg::LONG_DELAY;
   end

   // Next state of the sequencer
   always_comb begin
      next_state = state;
      next_opt = opt;
      next_cnt = cnt;
      case (state)
         ST_LOAD: begin
            // Byte caught once, on the first edge after release
            next_opt = option_byte;
            next_cnt = '0;
            next_state = ST_WAIT;
         end
         ST_WAIT: begin
            // Count the stabilization window before letting the CPU go
            if (cnt == delay_len - 1'b1) begin
               next_state = ST_RUN;
               next_cnt = '0;
            end else begin
               next_cnt = cnt + 1'b1;
            end
         end
         ST_RUN: begin
            if (halt_req) begin
               next_state = ST_HALT;
            end
         end
         ST_HALT: begin
            // Leaving halt reuses the same window as reset
            if (wakeup) begin
               next_state = ST_WAIT;
               next_cnt = '0;
            end
         end
         default: begin
            next_state = ST_LOAD;
         end
      endcase
      next_cpu_run = (next_state == ST_RUN);
   end

   // Sequencer registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= ST_LOAD;
         opt <= '1;
         cnt <= '0;
         cpu_run <= 1'b0;
      end else begin
         state <= next_state;
         opt <= next_opt;
         cnt <= next_cnt;
         cpu_run <= next_cpu_run;
      end
   end

   // ---------------------------------------------------------------
   // Clock and pad configuration outputs
   // ---------------------------------------------------------------
   obcc_pkg::obcc_src_e next_src;
   logic [2:0] next_range;
   logic next_pll, next_pkg, next_fault, cfg_fault;
   logic [NPADS-1:0] next_pullup;

   // Decode the frozen byte; a bad doubler combination is only flagged,
   // since the configuring party owns that choice.
   always_comb begin
      next_src = src_decode(opt.clock_source_type);
      next_range = range_decode(opt);
      next_pll = ~opt.pll_off;
      next_pkg = opt.package_select;
      next_fault = ~opt.pll_off &
                   ((next_src == obcc_pkg::OBCC_SRC_RC) |
                    (next_range != obcc_pkg::MEDIUM_POWER_RANGE));
      // Unbonded pads held as pulled-up inputs, drawing no current
      next_pullup = opt.package_select ? ~BOND_MASK_44[NPADS-1:0]
                                       : ~BOND_MASK_32[NPADS-1:0];
   end

   // Configuration registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clk_src_sel <= obcc_pkg::OBCC_SRC_RC;
         osc_current_range <= obcc_pkg::MEDIUM_POWER_RANGE;
         pll_enable <= 1'b0;
         package_44 <= 1'b0;
         cfg_fault <= 1'b0;
         pad_pullup_input <= '1;
      end else begin
         clk_src_sel <= next_src;
         osc_current_range <= next_range;
         pll_enable <= next_pll;
         package_44 <= next_pkg;
         cfg_fault <= next_fault;
         pad_pullup_input <= next_pullup;
      end
   end

   // ---------------------------------------------------------------
   // AHB-Lite slave
   // ---------------------------------------------------------------
   logic wr_pend, next_wr_pend;         // Write awaiting its data phase
   logic [11:0] wr_addr, next_wr_addr;
   logic next_halt_req;
   logic [31:0] next_rdata;
   logic addr_ok;

   // Take address phase; reads answer in the following data phase.
   // Status is read only: the option fields cannot be rewritten.
   always_comb begin
      addr_ok = hsel & hready & (htrans == obcc_pkg::HTRANS_NONSEQ);
      next_wr_pend = addr_ok & hwrite;
      next_wr_addr = addr_ok ? haddr[11:0] : wr_addr;
      next_rdata = obcc_pkg::RDATA_ZERO;
      next_halt_req = 1'b0;
      if (addr_ok & ~hwrite) begin
         if (haddr[11:0] == obcc_pkg::ADDR_STATUS) begin
            next_rdata[obcc_pkg::ST_OPT_LSB +: 8] = opt;
            next_rdata[obcc_pkg::ST_RUN_BIT] = cpu_run;
            next_rdata[obcc_pkg::ST_FAULT_BIT] = cfg_fault;
            next_rdata[obcc_pkg::ST_HALT_BIT] = (state == ST_HALT);
         end else if (haddr[11:0] == obcc_pkg::ADDR_HALT) begin
            next_rdata[obcc_pkg::ST_HALT_BIT] = (state == ST_HALT);
         end else begin
            next_rdata = obcc_pkg::RDATA_ZERO;
         end
      end
      if (wr_pend && wr_addr == obcc_pkg::ADDR_HALT) begin
         next_halt_req = hwdata[obcc_pkg::HALT_REQ_BIT];
      end
   end

   // Bus registers; the slave never stalls and never errors
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= '0;
         halt_req <= 1'b0;
         hrdata <= obcc_pkg::RDATA_ZERO;
         hreadyout <= 1'b1;
         hresp <= obcc_pkg::HRESP_OKAY;
      end else begin
         wr_pend <= next_wr_pend;
         wr_addr <= next_wr_addr;
         halt_req <= next_halt_req;
         hrdata <= next_rdata;
         hreadyout <= 1'b1;
         hresp <= obcc_pkg::HRESP_OKAY;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   logic [obcc_pkg::CNT_W-1:0] wait_seen; // Cycles spent stabilizing
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wait_seen <= '0;
      end else if (state == ST_WAIT) begin
         wait_seen <= wait_seen + 1'b1;
      end else begin
         wait_seen <= '0;
      end
   end

   sequence run_released;
      $rose(cpu_run);
   endsequence
   sequence settled;
      cpu_run && $past(cpu_run);
   endsequence

   a_wait_length: assert property (@(posedge hclk) disable iff (!hresetn)
      run_released |-> wait_seen == delay_len)
      else $error("Stabilization window length wrong");
   a_clock_select: assert property (@(posedge hclk) disable iff (!hresetn)
      settled |-> clk_src_sel == src_decode(opt.clock_source_type))
      else $error("Clock source selection wrong");
   a_range_resonator: assert property (@(posedge hclk) disable iff (!hresetn)
      settled and (opt.clock_source_type == obcc_pkg::SRC_RESONATOR)
      |-> osc_current_range == opt.oscillator_range)
      else $error("Resonator range not applied");
   a_range_external: assert property (@(posedge hclk) disable iff (!hresetn)
      settled and (clk_src_sel == obcc_pkg::OBCC_SRC_EXTERNAL)
      |-> osc_current_range == obcc_pkg::MEDIUM_POWER_RANGE)
      else $error("External source not at medium power");
   a_pll_enable: assert property (@(posedge hclk) disable iff (!hresetn)
      settled |-> pll_enable != opt.pll_off)
      else $error("Doubler enable inverted");
   a_package_pin: assert property (@(posedge hclk) disable iff (!hresetn)
      settled |-> package_44 == opt.package_select)
      else $error("Package variant wrong");
   a_pad_pullup: assert property (@(posedge hclk) disable iff (!hresetn)
      settled |-> pad_pullup_input == (package_44 ? ~BOND_MASK_44[NPADS-1:0]
                                                  : ~BOND_MASK_32[NPADS-1:0]))
      else $error("Unbonded pads not pulled up");
   a_opt_frozen: assert property (@(posedge hclk) disable iff (!hresetn)
      state != ST_LOAD && $past(state) != ST_LOAD |-> $stable(opt))
      else $error("Option fields changed at run time");
endmodule

// *** hw/obcc_pkg.sv ***
// Purpose: Shared constants and types for the option byte clock config.
// Assumes: Option byte is presented by the nonvolatile array from reset.
// Notes: All offsets, fields and delay counts of the block live here.
package obcc_pkg;
   // ---------------------------------------------------------------
   // Option byte layout, bit 7 down to bit 0
   // ---------------------------------------------------------------
   typedef struct packed {
      logic package_select;        // 1: 44-lead, 0: 32-lead
      logic reset_delay_select;    // 0: long delay, 1: short delay
      logic [1:0] clock_source_type;
      logic [2:0] oscillator_range;
      logic pll_off;               // 0: doubler on, 1: bypassed
   } obcc_opt_s;

   // Clock source codes as stored in the byte
   localparam logic [1:0] SRC_RESONATOR = 2'h0;
   localparam logic [1:0] SRC_RC = 2'h2;
   localparam logic [1:0] SRC_EXTERNAL = 2'h3;

   // Resonator current ranges
   localparam logic [2:0] LOW_POWER_RANGE = 3'h0;
   localparam logic [2:0] MEDIUM_POWER_RANGE = 3'h1;
   localparam logic [2:0] MEDIUM_SPEED_RANGE = 3'h2;
   localparam logic [2:0] HIGH_SPEED_RANGE = 3'h3;

   // Decoded main clock source
   typedef enum logic [1:0] {
      OBCC_SRC_RESONATOR,
      OBCC_SRC_RC,
      OBCC_SRC_EXTERNAL
   } obcc_src_e;

   // Stabilization lengths in CPU cycles
   localparam int LONG_DELAY_CYCLES = 4096;
   localparam int SHORT_DELAY_CYCLES = 256;
   localparam int CNT_W = 13;
   localparam logic [CNT_W-1:0] LONG_DELAY = 13'h1000;
   localparam logic [CNT_W-1:0] SHORT_DELAY = 13'h0100;

   // Register byte addresses
   localparam logic [11:0] ADDR_STATUS = 12'h000;
   localparam logic [11:0] ADDR_HALT = 12'h004;

   // Status and halt register fields
   localparam int ST_OPT_LSB = 0;
   localparam int ST_RUN_BIT = 8;
   localparam int ST_FAULT_BIT = 9;
   localparam int ST_HALT_BIT = 10;
   localparam int HALT_REQ_BIT = 0;

   // Bus constants
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'h0;
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
endpackage

// *** tb/obcc_source_model.sv ***
// Purpose: Configuring party and clock source in front of the block.
// Assumes: Requests are legalized the way a careful tool would.
// Notes: Produces the option byte that the block samples at reset.
`timescale 1ns/10ps
module obcc_source_model (
   input wire logic pkg,
   input wire logic short_delay,
   input wire logic [1:0] src,
   input wire logic [2:0] rng,
   input wire logic pll_on,
   output obcc_pkg::obcc_opt_s option_byte
);
   // -------------------------------------------------------------
   // Byte assembly
   // -------------------------------------------------------------
   // A resonator never gets the short delay: crystals settle slowly
   always_comb begin
      option_byte.package_select = pkg;
      option_byte.reset_delay_select = short_delay &&
         (src != obcc_pkg::SRC_RESONATOR);
      option_byte.clock_source_type = src;
      // External clock always uses the medium power range
      option_byte.oscillator_range = (src == obcc_pkg::SRC_EXTERNAL) ?
         obcc_pkg::MEDIUM_POWER_RANGE : rng;
      // Doubler only on with a source code other than SRC_RC and only with the medium power range
      option_byte.pll_off = !(pll_on && src != obcc_pkg::SRC_RC &&
         option_byte.oscillator_range ==
         obcc_pkg::MEDIUM_POWER_RANGE);
   end
endmodule

// *** tb/option_byte_clock_config_bench.sv ***
// Purpose: Self-checking bench for the option byte clock config.
// Assumes: Zero wait slave; tasks never assume a latency.
// Notes: Table rows for decoding, hand tests for halt and freeze.
`timescale 1ns/10ps
module option_byte_clock_config_bench;
   // -------------------------------------------------------------
   // Signals
   // -------------------------------------------------------------
   localparam logic [31:0] BM44 = 32'hffff_ffff; // Bonded pads, 44
   localparam logic [31:0] BM32 = 32'h00ff_ffff; // Bonded pads, 32
   typedef struct {
      logic pkg, sh;
      logic [1:0] src;
      logic [2:0] rng;
      logic pll;
      obcc_pkg::obcc_src_e esrc;
      logic [2:0] erng;
      logic epll;
      logic [31:0] epad;
   } obcc_row_s;
   logic hclk, hresetn, wakeup, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd, st0;
   logic [1:0] htrans;
   logic [2:0] hsize, osc_current_range;
   logic cpu_run, pll_enable, package_44;
   logic pkg, sh, pll_on;
   logic [1:0] src;
   logic [2:0] rng;
   logic [31:0] pad_pullup_input;
   obcc_pkg::obcc_src_e clk_src_sel;
   obcc_pkg::obcc_opt_s option_byte;
   int fails, checks_done, cnt;
   obcc_row_s rows [7];
   assign hready = hreadyout; // Single slave drives the bus ready
   obcc_source_model obcc_source_model_inst (.pkg(pkg),
      .short_delay(sh), .src(src), .rng(rng), .pll_on(pll_on),
      .option_byte(option_byte));
   obcc_config #(.BOND_MASK_44(BM44), .BOND_MASK_32(BM32))
      obcc_config_inst (.hclk(hclk), .hresetn(hresetn),
      .option_byte(option_byte), .wakeup(wakeup), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .cpu_run(cpu_run),
      .clk_src_sel(clk_src_sel), .osc_current_range(osc_current_range),
      .pll_enable(pll_enable), .package_44(package_44),
      .pad_pullup_input(pad_pullup_input));
   // -------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Called right after a rising edge; holds until hready sampled
   task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= obcc_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   // Count edges from a start point until the CPU is released
   task wait_run;
      cnt = 0;
      do begin
         @(posedge hclk);
         #1;
         cnt++;
      end while (cpu_run !== 1'b1 && cnt < 5000);
      @(posedge hclk);
   endtask
   task start(input obcc_row_s r);
      {pkg, sh, src, rng, pll_on} <= {r.pkg, r.sh, r.src, r.rng, r.pll};
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      chk(pad_pullup_input, 32'hffff_ffff);
      chk(cpu_run, 1'b0);
      hresetn <= 1'b1;
      wait_run;
   endtask
   task complete_run;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // -------------------------------------------------------------
   // Clock and watchdog
   // -------------------------------------------------------------
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   // About 18k cycles expected; cut off well beyond that
   initial begin
      repeat (40000) @(posedge hclk);
      fails++;
      complete_run;
   end
   // -------------------------------------------------------------
   // Main sequence; software never touches pad setup
   // -------------------------------------------------------------
   initial begin
      // Reset and option inputs are left to start, so none is set twice
      {wakeup, hsel, hwrite} = '0;
      {haddr, hwdata, htrans} = '0;
      hsize = 3'h2;
      rows = '{
         '{1, 0, 0, 3, 0, obcc_pkg::OBCC_SRC_RESONATOR, 3, 0, ~BM44},
         '{0, 0, 0, 1, 1, obcc_pkg::OBCC_SRC_RESONATOR, 1, 1, ~BM32},
         '{1, 1, 2, 0, 0, obcc_pkg::OBCC_SRC_RC, 0, 0, ~BM44},
         '{0, 1, 3, 1, 1, obcc_pkg::OBCC_SRC_EXTERNAL, 1, 1, ~BM32},
         '{1, 0, 0, 0, 0, obcc_pkg::OBCC_SRC_RESONATOR, 0, 0, ~BM44},
         '{0, 0, 0, 2, 0, obcc_pkg::OBCC_SRC_RESONATOR, 2, 0, ~BM32},
         '{1, 1, 1, 4, 0, obcc_pkg::OBCC_SRC_RC, 4, 0, ~BM44}};
      foreach (rows[i]) begin
         start(rows[i]);
         // One extra edge after release is spent catching the byte
         chk(cnt, (rows[i].sh ? obcc_pkg::SHORT_DELAY_CYCLES
                              : obcc_pkg::LONG_DELAY_CYCLES) + 1);
         chk(clk_src_sel, rows[i].esrc);
         chk(osc_current_range, rows[i].erng);
         chk(pll_enable, rows[i].epll);
         chk(package_44, rows[i].pkg);
         chk(pad_pullup_input, rows[i].epad);
         ahb(1'b0, 32'h0, 32'h0);
         chk(rd, {23'h0, 1'b1, option_byte});
      end
      // Byte changes at run time and status writes change nothing
      st0 = rd;
      {pkg, src, pll_on} <= {1'b0, 2'h0, 1'b1};
      ahb(1'b1, 32'h0, 32'h0000_00ff);
      ahb(1'b0, 32'h0, 32'h0);
      chk(rd, st0);
      chk(package_44, 1'b1);
      chk(clk_src_sel, obcc_pkg::OBCC_SRC_RC);
      ahb(1'b0, 32'h10, 32'h0);
      chk(rd, 32'h0);
      // Halt, then wake with the short delay in force
      start(rows[2]);
      ahb(1'b1, 32'h4, 32'h1);
      @(posedge hclk);
      #1;
      chk(cpu_run, 1'b0);
      @(posedge hclk);
      ahb(1'b0, 32'h4, 32'h0);
      chk(rd[10], 1'b1);
      wakeup <= 1'b1;
      @(posedge hclk);
      wakeup <= 1'b0;
      wait_run;
      chk(cnt, obcc_pkg::SHORT_DELAY_CYCLES);
      // Bus traffic never reached the pads: still in the 44-lead setup
      chk(pad_pullup_input, ~BM44);
      chk(hresp, obcc_pkg::HRESP_OKAY);
      chk(hreadyout, 1'b1);
      complete_run;
   end
endmodule
